// *** rtl/asc_pkg.sv ***
package asc_pkg;

   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_CHAN   = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_MASK   = 8'h0C;
   localparam logic [7:0] ADDR_RESULT = 8'h10;

   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_START_BIT  = 1;
   localparam int CHAN_LEFT_BIT   = 0;
   localparam int CHAN_DIFF_BIT   = 1;
   localparam int STAT_DONE_BIT   = 0;
   localparam int STAT_SLEEP_BIT  = 1;
   localparam int RES_HIGH_LSB    = 8;

   localparam logic        RST_BIT  = 1'h0;
   localparam logic [9:0]  RST_CODE = 10'h000;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // -----------------------------------------------------------------
   // sleep modes and bus codes
   // -----------------------------------------------------------------
   localparam logic [2:0] SLEEP_IDLE  = 3'h0;
   localparam logic [2:0] SLEEP_NOISE = 3'h1;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   // -----------------------------------------------------------------
   // result coding
   // -----------------------------------------------------------------
   localparam int SAMPLE_W = 12;
   localparam logic signed [SAMPLE_W-1:0] SE_MIN   = 12'sh000;
   localparam logic signed [SAMPLE_W-1:0] SE_MAX   = 12'sh3FF;
   localparam logic signed [SAMPLE_W-1:0] DIFF_MAX = 12'sh1FF;
   localparam logic signed [SAMPLE_W-1:0] DIFF_MIN = 12'shE00;
   localparam logic [9:0] CODE_ZERO     = 10'h000;
   localparam logic [9:0] CODE_SE_TOP   = 10'h3FF;
   localparam logic [9:0] CODE_DIFF_POS = 10'h1FF;
   localparam logic [9:0] CODE_DIFF_NEG = 10'h200;

   typedef enum logic [1:0] {
      ASC_IDLE  = 2'h0,
      ASC_START = 2'h1,
      ASC_WAIT  = 2'h3
   } asc_state_type;

   // clamps the array value into the 10-bit code of the selected mode
   function automatic logic [9:0] asc_sat_code(input logic signed [SAMPLE_W-1:0] v,
                                               input logic                       diff);
      logic [9:0] c;
      c = v[9:0];
      if (diff) begin
         if (v > DIFF_MAX) c = CODE_DIFF_POS;
         else if (v < DIFF_MIN) c = CODE_DIFF_NEG;
      end else begin
         if (v < SE_MIN) c = CODE_ZERO;
         else if (v > SE_MAX) c = CODE_SE_TOP;
      end
      return c;
   endfunction

endpackage

// *** rtl/asc_result_format.sv ***
`timescale 1ns/1ps
module asc_result_format
   import asc_pkg::*;
(
   input  wire logic [9:0] code,
   input  wire logic       left_adjust_select,
   output logic      [7:0] result_low_byte,
   output logic      [7:0] result_high_byte
);

   // -----------------------------------------------------------------
   // byte alignment, follows the select at once
   // -----------------------------------------------------------------
   always_comb begin
      if (left_adjust_select) begin
         result_high_byte = code[9:2];
         result_low_byte  = {code[1:0], 6'h00};
      end else begin
         result_low_byte  = code[7:0];
         result_high_byte = {6'h00, code[9:8]};
      end
   end

endmodule // asc_result_format

// *** rtl/asc_converter_ctrl.sv ***
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module asc_converter_ctrl
   import asc_pkg::*;
(
   input  wire logic                REF_CLK,
   input  wire logic                RST,
   input  wire logic                HSEL,
   input  wire logic [31:0]         HADDR,
   input  wire logic [1:0]          HTRANS,
   input  wire logic                HWRITE,
   input  wire logic [2:0]          HSIZE,
   input  wire logic [31:0]         HWDATA,
   input  wire logic                HREADY,
   output logic      [31:0]         HRDATA,
   output logic                     HREADYOUT,
   output logic                     HRESP,
   input  wire logic                CPU_HALTED,
   input  wire logic [2:0]          SLEEP_MODE,
   input  wire logic                VECTOR_ACK,
   output logic                     IRQ,
   output logic                     CONV_ENABLE,
   output logic                     SAMPLE_START,
   output logic                     SAMPLE_DIFF,
   input  wire logic                SAMPLE_DONE,
   input  wire logic [SAMPLE_W-1:0] SAMPLE_VALUE
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   logic          wr_pend_reg, wr_pend_next;
   logic [7:0]    wr_addr_reg, wr_addr_next;
   logic [31:0]   hrdata_reg,  hrdata_next;
   logic          enable_reg,  enable_next;
   logic          left_reg,    left_next;
   logic          diff_reg,    diff_next;
   logic          flag_reg,    flag_next;
   logic          mask_reg,    mask_next;
   logic          sleep_reg,   sleep_next;
   logic          start_reg,   start_next;
   logic          irq_reg,     irq_next;
   logic          halted_reg;
   logic [9:0]    code_reg,    code_next;
   asc_state_type state_reg,   state_next;
   logic [7:0]    low_byte;
   logic [7:0]    high_byte;
   logic          halt_rise;
   logic          sleep_go;
   logic          sw_go;
   logic          conv_done;

   function automatic logic wr_hit(input logic pend, input logic [7:0] a,
                                   input logic [7:0] target);
      return pend && (a == target);
   endfunction

   asc_result_format u_format (
      .code               (code_reg),
      .left_adjust_select (left_reg),
      .result_low_byte    (low_byte),
      .result_high_byte   (high_byte)
   );

   // -----------------------------------------------------------------
   // ahb-lite slave, zero wait states
   // -----------------------------------------------------------------
   always_comb begin
      logic addr_phase;
      addr_phase   = HSEL && HREADY && HTRANS[1];
      wr_pend_next = addr_phase && HWRITE;
      wr_addr_next = addr_phase ? HADDR[7:0] : wr_addr_reg;
      hrdata_next  = RST_WORD;
      if (addr_phase && !HWRITE) begin
         unique case (HADDR[7:0])
            ADDR_CTRL: begin
               hrdata_next[CTRL_ENABLE_BIT] = enable_reg;
               hrdata_next[CTRL_START_BIT]  = (state_reg != ASC_IDLE);
            end
            ADDR_CHAN: begin
               hrdata_next[CHAN_LEFT_BIT] = left_reg;
               hrdata_next[CHAN_DIFF_BIT] = diff_reg;
            end
            ADDR_STATUS: begin
               hrdata_next[STAT_DONE_BIT]  = flag_reg;
               hrdata_next[STAT_SLEEP_BIT] = sleep_reg;
            end
            ADDR_MASK:   hrdata_next[STAT_DONE_BIT] = mask_reg;
            ADDR_RESULT: hrdata_next[15:0] = {high_byte, low_byte};
            default:     hrdata_next = RST_WORD;
         endcase
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         wr_pend_reg <= RST_BIT;
         wr_addr_reg <= 8'h00;
         hrdata_reg  <= RST_WORD;
      end else begin
         wr_pend_reg <= wr_pend_next;
         wr_addr_reg <= wr_addr_next;
         hrdata_reg  <= hrdata_next;
      end
   end

   // -----------------------------------------------------------------
   // conversion control
   // -----------------------------------------------------------------
   always_comb begin
      logic wr_ctrl;
      logic wr_stat;
      wr_ctrl    = wr_hit(wr_pend_reg, wr_addr_reg, ADDR_CTRL);
      wr_stat    = wr_hit(wr_pend_reg, wr_addr_reg, ADDR_STATUS);
      // other sleep modes leave the enable alone
      enable_next = wr_ctrl ? HWDATA[CTRL_ENABLE_BIT] : enable_reg;
      left_next   = wr_hit(wr_pend_reg, wr_addr_reg, ADDR_CHAN)
                    ? HWDATA[CHAN_LEFT_BIT] : left_reg;
      diff_next   = wr_hit(wr_pend_reg, wr_addr_reg, ADDR_CHAN)
                    ? HWDATA[CHAN_DIFF_BIT] : diff_reg;
      mask_next   = wr_hit(wr_pend_reg, wr_addr_reg, ADDR_MASK)
                    ? HWDATA[STAT_DONE_BIT] : mask_reg;
      halt_rise   = CPU_HALTED && !halted_reg;
      // only a fresh halt starts one, so a woken cpu is not re-slept
      sleep_go    = halt_rise && enable_reg && (state_reg == ASC_IDLE)
                    && ((SLEEP_MODE == SLEEP_IDLE) || (SLEEP_MODE == SLEEP_NOISE));
      sw_go       = wr_ctrl && HWDATA[CTRL_START_BIT] && enable_next
                    && (state_reg == ASC_IDLE) && !sleep_go;
      conv_done   = (state_reg == ASC_WAIT) && SAMPLE_DONE && enable_next;
      state_next  = state_reg;
      start_next  = RST_BIT;
      sleep_next  = sleep_reg;
      unique case (state_reg)
         ASC_IDLE: begin
            if (sleep_go || sw_go) begin
               state_next = ASC_START;
               start_next = RST_BIT | 1'b1;
               sleep_next = sleep_go;
            end
         end
         ASC_START: state_next = enable_next ? ASC_WAIT : ASC_IDLE;
         ASC_WAIT: begin
            // a wake from another source does not stop it
            if (SAMPLE_DONE || !enable_next) state_next = ASC_IDLE;
         end
         default: state_next = ASC_IDLE;
      endcase
      if (state_next == ASC_IDLE) sleep_next = RST_BIT;
      // one capture feeds both bytes
      code_next = conv_done ? asc_sat_code($signed(SAMPLE_VALUE), diff_reg)
                            : code_reg;
      flag_next = flag_reg;
      if (VECTOR_ACK || (wr_stat && HWDATA[STAT_DONE_BIT])) flag_next = RST_BIT;
      if (conv_done) flag_next = 1'b1;
      irq_next = flag_next && mask_next;
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         enable_reg <= RST_BIT;
         left_reg   <= RST_BIT;
         diff_reg   <= RST_BIT;
         mask_reg   <= RST_BIT;
         flag_reg   <= RST_BIT;
         sleep_reg  <= RST_BIT;
         start_reg  <= RST_BIT;
         irq_reg    <= RST_BIT;
         halted_reg <= RST_BIT;
         code_reg   <= RST_CODE;
         state_reg  <= ASC_IDLE;
      end else begin
         enable_reg <= enable_next;
         left_reg   <= left_next;
         diff_reg   <= diff_next;
         mask_reg   <= mask_next;
         flag_reg   <= flag_next;
         sleep_reg  <= sleep_next;
         start_reg  <= start_next;
         irq_reg    <= irq_next;
         halted_reg <= CPU_HALTED;
         code_reg   <= code_next;
         state_reg  <= state_next;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign HRDATA       = hrdata_reg;
   assign HREADYOUT    = 1'b1;
   assign HRESP        = 1'b0;
   assign IRQ          = irq_reg;
   assign CONV_ENABLE  = enable_reg;
   assign SAMPLE_START = start_reg;
   assign SAMPLE_DIFF  = diff_reg;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   sequence s_sleep_entry;
      CPU_HALTED && !halted_reg && enable_reg && state_reg == ASC_IDLE
      && (SLEEP_MODE == SLEEP_IDLE || SLEEP_MODE == SLEEP_NOISE);
   endsequence
   sequence s_launch;
      SAMPLE_START && sleep_reg ##1 state_reg == ASC_WAIT;
   endsequence

   AST_SLEEP_START: assert property ((s_sleep_entry and !wr_pend_reg) |=> s_launch)
      else $error("sleep entry did not launch a conversion");
   AST_DONE_IRQ: assert property (conv_done && mask_reg && !wr_pend_reg
                                  |=> flag_reg ##1 IRQ)
      else $error("completion did not raise the interrupt");
   AST_CONTINUE: assert property (state_reg == ASC_WAIT && !SAMPLE_DONE && !wr_pend_reg
                                  |=> state_reg == ASC_WAIT)
      else $error("conversion dropped before completion");
   AST_NO_RESLEEP: assert property (state_reg == ASC_IDLE && !halt_rise && !wr_pend_reg
                                    |=> !SAMPLE_START)
      else $error("conversion started without a new halt");
   AST_ENABLE_KEPT: assert property (!wr_pend_reg |=> enable_reg == $past(enable_reg))
      else $error("enable changed without a write");
   AST_CODE_PAIR: assert property (!conv_done |=> $stable(code_reg))
      else $error("result changed outside a completion");
   AST_SE_FLOOR: assert property (conv_done && !diff_reg && $signed(SAMPLE_VALUE) < SE_MIN
                                  |=> code_reg == CODE_ZERO)
      else $error("negative single-ended value not floored");
   AST_DIFF_SAT: assert property (conv_done && diff_reg && $signed(SAMPLE_VALUE) > DIFF_MAX
                                  |=> code_reg == CODE_DIFF_POS)
      else $error("differential overrange not saturated");
   AST_SIGN: assert property (conv_done && diff_reg && $signed(SAMPLE_VALUE) < SE_MIN
                              |=> code_reg[9])
      else $error("negative differential without sign bit");
   AST_RIGHT: assert property (!left_reg |-> low_byte == code_reg[7:0]
                               && high_byte[1:0] == code_reg[9:8])
      else $error("right alignment wrong");
   AST_LEFT: assert property (left_reg |-> high_byte == code_reg[9:2]
                              && low_byte[7:6] == code_reg[1:0])
      else $error("left alignment wrong");
   AST_FLAG_CLEAR: assert property (VECTOR_ACK && !conv_done |=> !flag_reg)
      else $error("vector entry did not clear the flag");
   AST_SET_WINS: assert property (conv_done |=> flag_reg)
      else $error("completion lost against a clear");

endmodule // asc_converter_ctrl

// *** dv/asc_cpu_model.sv ***
`timescale 1ns/1ps
module asc_cpu_model
   import asc_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       sleep_req,
   input  wire logic [2:0] req_mode,
   input  wire logic       other_wake,
   input  wire logic       irq,
   output logic            cpu_halted,
   output logic      [2:0] sleep_mode,
   output logic            vector_ack,
   output logic            woke_irq
);
   // ----------------------------------------------------------
   // sleep controller: halts on a sleep command, wakes on irq
   // ----------------------------------------------------------
   always @(posedge ref_clk) begin
      if (rst) begin
         cpu_halted <= 1'h0;
         sleep_mode <= 3'h0;
         vector_ack <= 1'h0;
         woke_irq   <= 1'h0;
      end else begin
         vector_ack <= 1'h0;
         if (sleep_req && !cpu_halted) begin
            cpu_halted <= 1'h1;
            sleep_mode <= req_mode;
            woke_irq   <= 1'h0;
         end else if (cpu_halted && irq) begin
            cpu_halted <= 1'h0;
            vector_ack <= 1'h1;
            woke_irq   <= 1'h1;
         end else if (cpu_halted && other_wake) begin
            cpu_halted <= 1'h0;
         end
      end
   end
endmodule // asc_cpu_model

// *** dv/asc_converter_ctrl_test.sv ***
`timescale 1ns/1ps
module asc_converter_ctrl_test;
   import asc_pkg::*;
   logic REF_CLK, RST, HSEL, HWRITE, HREADYOUT, HRESP, IRQ, CONV_ENABLE, SAMPLE_START;
   logic SAMPLE_DIFF, SAMPLE_DONE, CPU_HALTED, VECTOR_ACK, sleep_req, other_wake, woke_irq;
   logic [31:0] HADDR, HWDATA, HRDATA;
   logic [1:0]  HTRANS;
   logic [2:0]  SLEEP_MODE, req_mode;
   logic [SAMPLE_W-1:0] SAMPLE_VALUE, arr_val;
   logic        rd_dp;
   logic [31:0] exp_q[$];
   string       nm_q[$];
   int n_mismatch, checks_done, n_start, arr_cnt, arr_delay, i, s0;
   logic [12:0] tbl [12] = '{13'h0FFB, 13'h0000, 13'h03FF, 13'h0400, 13'h02A5, 13'h11FF,
                            13'h1200, 13'h1E00, 13'h1C00, 13'h1FFF, 13'h1E70, 13'h1001};
   logic [9:0]  code;

   asc_converter_ctrl i_asc_converter_ctrl (.REF_CLK(REF_CLK), .RST(RST), .HSEL(HSEL),
      .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
      .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
      .CPU_HALTED(CPU_HALTED), .SLEEP_MODE(SLEEP_MODE), .VECTOR_ACK(VECTOR_ACK), .IRQ(IRQ),
      .CONV_ENABLE(CONV_ENABLE), .SAMPLE_START(SAMPLE_START), .SAMPLE_DIFF(SAMPLE_DIFF),
      .SAMPLE_DONE(SAMPLE_DONE), .SAMPLE_VALUE(SAMPLE_VALUE));
   asc_cpu_model i_asc_cpu_model (.ref_clk(REF_CLK), .rst(RST), .sleep_req(sleep_req),
      .req_mode(req_mode), .other_wake(other_wake), .irq(IRQ), .cpu_halted(CPU_HALTED),
      .sleep_mode(SLEEP_MODE), .vector_ack(VECTOR_ACK), .woke_irq(woke_irq));

   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, string nm);
      @(posedge REF_CLK);
      HSEL <= 1'h1; HTRANS <= HTRANS_NONSEQ; HWRITE <= w; HADDR <= {24'h0, a};
      do @(posedge REF_CLK); while (HREADYOUT !== 1'h1);
      HTRANS <= 2'h0; HWDATA <= w ? d : 32'h0;
      if (!w) begin
         exp_q.push_back(d);
         nm_q.push_back(nm);
         rd_dp <= 1'h1;
      end
      do @(posedge REF_CLK); while (HREADYOUT !== 1'h1);
      rd_dp <= 1'h0;
   endtask
   task automatic wait_irq();
      for (int k = 0; k < 300 && IRQ !== 1'h1; k++) @(posedge REF_CLK);
      check("irq", IRQ, 32'h1);
   endtask
   task automatic sleep(input logic [2:0] m);
      @(posedge REF_CLK);
      sleep_req <= 1'h1; req_mode <= m;
      @(posedge REF_CLK);
      sleep_req <= 1'h0;
      repeat (3) @(posedge REF_CLK);
   endtask
   function automatic logic [9:0] ref_code(input logic d, input logic signed [11:0] v);
      if (d) return (v > 511) ? 10'h1FF : (v < -512) ? 10'h200 : v[9:0];
      return (v < 0) ? 10'h000 : (v > 1023) ? 10'h3FF : v[9:0];
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // read data is taken at the end of the data phase
   always @(posedge REF_CLK) begin
      if (rd_dp && HREADYOUT === 1'h1 && exp_q.size() > 0)
         check(nm_q.pop_front(), HRDATA, exp_q.pop_front());
   end
   // analog array stand-in: a line with no valid sample toggles every cycle
   always @(posedge REF_CLK) begin
      SAMPLE_DONE <= 1'h0;
      SAMPLE_VALUE <= ~SAMPLE_VALUE;
      if (SAMPLE_START === 1'h1) begin
         n_start++;
         arr_cnt = arr_delay;
      end else if (arr_cnt > 1) arr_cnt--;
      else if (arr_cnt == 1) begin
         arr_cnt = 0;
         SAMPLE_DONE <= 1'h1;
         SAMPLE_VALUE <= arr_val;
      end
   end

   initial begin
      REF_CLK = 1'h0;
      forever #5 REF_CLK = ~REF_CLK;
   end
   initial begin
      #300000;
      n_mismatch++;
      complete_run();
   end

   // ----------------------------------------------------------
   // tests
   // ----------------------------------------------------------
   initial begin
      RST = 1'h1; HSEL = 1'h0; HADDR = 32'h0; HTRANS = 2'h0; HWRITE = 1'h0; HWDATA = 32'h0;
      sleep_req = 1'h0; req_mode = 3'h0; other_wake = 1'h0; rd_dp = 1'h0;
      SAMPLE_DONE = 1'h0; SAMPLE_VALUE = 12'h5A5; arr_val = 12'h0; arr_cnt = 0; n_start = 0;
      void'($urandom(32'h81a60e56));
      repeat (4) @(posedge REF_CLK);
      RST <= 1'h0;
      for (i = 0; i < 6; i++) bus(1'h0, 8'(4 * i), RST_WORD, "reset value");
      $display("test reset done");
      bus(1'h1, ADDR_MASK, 32'h1, "");
      bus(1'h1, ADDR_CTRL, 32'h1, "");
      arr_val = 12'($urandom_range(0, 1023));
      arr_delay = $urandom_range(1, 12);
      s0 = n_start;
      sleep(SLEEP_NOISE);
      check("sleep start", 32'(n_start - s0), 32'h1);
      wait_irq();
      repeat (4) @(posedge REF_CLK);
      check("woke by irq", woke_irq, 32'h1);
      bus(1'h0, ADDR_STATUS, 32'h0, "flag after vector");
      bus(1'h0, ADDR_RESULT, {22'h0, arr_val[9:0]}, "sleep result");
      repeat (20) @(posedge REF_CLK);
      check("stays awake", CPU_HALTED, 32'h0);
      check("no restart", 32'(n_start - s0), 32'h1);
      $display("test noise sleep done");
      arr_delay = 40;
      sleep(SLEEP_IDLE);
      other_wake <= 1'h1;
      @(posedge REF_CLK);
      other_wake <= 1'h0;
      repeat (2) @(posedge REF_CLK);
      check("woken early", CPU_HALTED, 32'h0);
      wait_irq();
      bus(1'h0, ADDR_STATUS, 32'h1, "late flag");
      bus(1'h1, ADDR_STATUS, 32'h1, "");
      bus(1'h0, ADDR_STATUS, 32'h0, "flag w1c");
      @(posedge REF_CLK);
      check("irq cleared", IRQ, 32'h0);
      $display("test other wake done");
      s0 = n_start;
      sleep(3'h2);
      check("enable kept", CONV_ENABLE, 32'h1);
      bus(1'h1, ADDR_CTRL, 32'h0, "");
      other_wake <= 1'h1;
      @(posedge REF_CLK);
      other_wake <= 1'h0;
      sleep(3'h3);
      other_wake <= 1'h1;
      @(posedge REF_CLK);
      other_wake <= 1'h0;
      check("no sleep start", 32'(n_start - s0), 32'h0);
      check("enable off", CONV_ENABLE, 32'h0);
      $display("test other modes done");
      for (i = 0; i < 12; i++) begin
         arr_val = tbl[i][11:0];
         arr_delay = $urandom_range(1, 12);
         code = ref_code(tbl[i][12], tbl[i][11:0]);
         bus(1'h1, ADDR_CHAN, {30'h0, tbl[i][12], 1'h0}, "");
         bus(1'h1, ADDR_CTRL, 32'h3, "");
         wait_irq();
         check("sample diff", SAMPLE_DIFF, {31'h0, tbl[i][12]});
         bus(1'h0, ADDR_RESULT, {22'h0, code}, "right result");
         bus(1'h1, ADDR_CHAN, {30'h0, tbl[i][12], 1'h1}, "");
         bus(1'h0, ADDR_RESULT, {16'h0, code, 6'h0}, "left result");
         bus(1'h1, ADDR_STATUS, 32'h1, "");
      end
      $display("test coding done");
      complete_run();
   end
endmodule // asc_converter_ctrl_test
